// ### hdl/cfl_flag_unit.sv
`timescale 1ns/1ns
`default_nettype none
module cfl_flag_unit (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] flags_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] opa_r, opb_r, flags_r, flags_nxt, calc;
    logic [15:0] wacc_r, wopnd_r, result_r, res_nxt;
    logic [23:0] spec_r;
    cfl_pkg::cfl_op_e op_r;
    logic go_r, pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic take, done, wr;
    logic [7:0] x8, y8, res8, corr;
    logic cin, sub, v8, cy, wide;
    logic [8:0] r9;
    logic [4:0] h5;
    logic [16:0] r17;
    logic [12:0] h13;

    // ------------------------------------------------------------
    // apb slave: one wait state, write lands when pready is seen
    // ------------------------------------------------------------
    assign take = psel & penable & ~pready_r;
    assign done = psel & penable & pready_r;
    assign wr = done & pwrite;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= take;
            pslverr_r <= take & (paddr > cfl_pkg::ADDR_FLAGS
                                 | paddr[1:0] != 2'h0);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            prdata_r <= 32'h00000000;
        else if (take && !pwrite)
        begin
            if (paddr == cfl_pkg::ADDR_OPA)
                prdata_r <= {24'h000000, opa_r};
            else if (paddr == cfl_pkg::ADDR_OPB)
                prdata_r <= {24'h000000, opb_r};
            else if (paddr == cfl_pkg::ADDR_WACC)
                prdata_r <= {16'h0000, wacc_r};
            else if (paddr == cfl_pkg::ADDR_WOPND)
                prdata_r <= {16'h0000, wopnd_r};
            else if (paddr == cfl_pkg::ADDR_CMD)
                prdata_r <= {spec_r, 3'h0, op_r};
            else if (paddr == cfl_pkg::ADDR_RESULT)
                prdata_r <= {16'h0000, result_r};
            else if (paddr == cfl_pkg::ADDR_FLAGS)
                prdata_r <= {24'h000000, flags_r};
            else
                prdata_r <= 32'h00000000;
        end
        else
            prdata_r <= 32'h00000000;
    end

    // ------------------------------------------------------------
    // command: a write starts one execute cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            op_r <= cfl_pkg::OP_ADD8;
            spec_r <= cfl_pkg::SPEC_RST;
            go_r <= 1'b0;
        end
        else
        begin
            go_r <= wr & (paddr == cfl_pkg::ADDR_CMD);
            if (wr && paddr == cfl_pkg::ADDR_CMD)
            begin
                op_r <= cfl_pkg::cfl_op_e'(pwdata[cfl_pkg::CMD_OP_LSB +:
                                                  cfl_pkg::CMD_OP_W]);
                spec_r <= pwdata[cfl_pkg::CMD_SPEC_LSB +: cfl_pkg::SPEC_W];
            end
        end
    end

    // ------------------------------------------------------------
    // operand registers; results other than compare write back to the accumulators
    // ------------------------------------------------------------
    // byte and word operands
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            opa_r <= cfl_pkg::BYTE_RST;
            opb_r <= cfl_pkg::BYTE_RST;
            wacc_r <= cfl_pkg::WORD_RST;
            wopnd_r <= cfl_pkg::WORD_RST;
        end
        else
        begin
            if (go_r && !wide && op_r != cfl_pkg::OP_CMP8)
                opa_r <= res8;
            else if (wr && paddr == cfl_pkg::ADDR_OPA)
                opa_r <= pwdata[7:0];
            if (wr && paddr == cfl_pkg::ADDR_OPB)
                opb_r <= pwdata[7:0];
            if (go_r && wide)
                wacc_r <= r17[15:0];
            else if (wr && paddr == cfl_pkg::ADDR_WACC)
                wacc_r <= pwdata[15:0];
            if (wr && paddr == cfl_pkg::ADDR_WOPND)
                wopnd_r <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // arithmetic and flag computation
    // ------------------------------------------------------------
    always_comb
    begin
        x8 = opa_r;
        y8 = opb_r;
        cin = 1'b0;
        sub = 1'b0;
        wide = 1'b0;
        corr = 8'h00;
        cy = flags_r[cfl_pkg::FLAG_C];
        case (op_r)
            cfl_pkg::OP_ADC8: cin = flags_r[cfl_pkg::FLAG_C];
            cfl_pkg::OP_SUB8: sub = 1'b1;
            cfl_pkg::OP_CMP8: sub = 1'b1;
            cfl_pkg::OP_SBC8:
            begin
                sub = 1'b1;
                cin = flags_r[cfl_pkg::FLAG_C];
            end
            cfl_pkg::OP_NEG8:
            begin
                x8 = 8'h00;
                y8 = opa_r;
                sub = 1'b1;
            end
            cfl_pkg::OP_INC8: y8 = 8'h01;
            cfl_pkg::OP_DEC8:
            begin
                y8 = 8'h01;
                sub = 1'b1;
            end
            cfl_pkg::OP_ADD16: wide = 1'b1;
            cfl_pkg::OP_ADC16:
            begin
                wide = 1'b1;
                cin = flags_r[cfl_pkg::FLAG_C];
            end
            cfl_pkg::OP_SBC16:
            begin
                wide = 1'b1;
                sub = 1'b1;
                cin = flags_r[cfl_pkg::FLAG_C];
            end
            default: ;
        endcase
        // half-carry taken at bit 4 (bit 12 for words)
        if (sub)
        begin
            r9 = {1'b0, x8} - {1'b0, y8} - {8'h00, cin};
            h5 = {1'b0, x8[3:0]} - {1'b0, y8[3:0]} - {4'h0, cin};
            r17 = {1'b0, wacc_r} - {1'b0, wopnd_r} - {16'h0000, cin};
            h13 = {1'b0, wacc_r[11:0]} - {1'b0, wopnd_r[11:0]}
                  - {12'h000, cin};
        end
        else
        begin
            r9 = {1'b0, x8} + {1'b0, y8} + {8'h00, cin};
            h5 = {1'b0, x8[3:0]} + {1'b0, y8[3:0]} + {4'h0, cin};
            r17 = {1'b0, wacc_r} + {1'b0, wopnd_r} + {16'h0000, cin};
            h13 = {1'b0, wacc_r[11:0]} + {1'b0, wopnd_r[11:0]}
                  + {12'h000, cin};
        end
        // signed overflow from operand and result signs
        if (wide)
            v8 = (wacc_r[15] ^ wopnd_r[15] ^ ~sub) & (r17[15] ^ wacc_r[15]);
        else
            v8 = (x8[7] ^ y8[7] ^ ~sub) & (r9[7] ^ x8[7]);
        res8 = r9[7:0];
        calc = 8'h00;
        calc[cfl_pkg::FLAG_H] = h5[4];
        calc[cfl_pkg::FLAG_N] = sub;
        calc[cfl_pkg::FLAG_C] = r9[8];
        calc[cfl_pkg::FLAG_PV] = v8;
        case (op_r)
            cfl_pkg::OP_AND8:
            begin
                res8 = opa_r & opb_r;
                calc[cfl_pkg::FLAG_H] = 1'b1;
            end
            cfl_pkg::OP_OR8: res8 = opa_r | opb_r;
            cfl_pkg::OP_XOR8: res8 = opa_r ^ opb_r;
            cfl_pkg::OP_CPL8:
            begin
                res8 = ~opa_r;
                calc[cfl_pkg::FLAG_H] = 1'b1;
                calc[cfl_pkg::FLAG_N] = 1'b1;
                calc[cfl_pkg::FLAG_C] = 1'b0;
            end
            cfl_pkg::OP_DECADJ:
            begin
                // correction steered by half-carry and add/subtract
                if (flags_r[cfl_pkg::FLAG_H] || opa_r[3:0] > 4'h9)
                    corr[3:0] = 4'h6;
                if (flags_r[cfl_pkg::FLAG_C] || opa_r > 8'h99)
                begin
                    corr[7:4] = 4'h6;
                    cy = 1'b1;
                end
                if (flags_r[cfl_pkg::FLAG_N])
                begin
                    res8 = opa_r - corr;
                    calc[cfl_pkg::FLAG_H] = flags_r[cfl_pkg::FLAG_H]
                                            & (opa_r[3:0] < 4'h6);
                end
                else
                begin
                    res8 = opa_r + corr;
                    calc[cfl_pkg::FLAG_H] = opa_r[3:0] > 4'h9;
                end
                calc[cfl_pkg::FLAG_N] = flags_r[cfl_pkg::FLAG_N];
                calc[cfl_pkg::FLAG_C] = cy;
            end
            default: ;
        endcase
        if (op_r >= cfl_pkg::OP_AND8 && op_r <= cfl_pkg::OP_XOR8)
        begin
            // the adder's half-carry means nothing for a logic op
            calc[cfl_pkg::FLAG_H] = op_r == cfl_pkg::OP_AND8;
            calc[cfl_pkg::FLAG_N] = 1'b0;
            calc[cfl_pkg::FLAG_C] = 1'b0;
        end
        // logic, complement and adjust ops select parity
        // even count of ones gives one
        if ((op_r >= cfl_pkg::OP_AND8 && op_r <= cfl_pkg::OP_CPL8)
            || op_r == cfl_pkg::OP_DECADJ)
            calc[cfl_pkg::FLAG_PV] = ~^res8;
        res_nxt = {8'h00, res8};
        if (wide)
        begin
            res_nxt = r17[15:0];
            calc[cfl_pkg::FLAG_H] = h13[12];
            calc[cfl_pkg::FLAG_C] = r17[16];
        end
        calc[cfl_pkg::FLAG_S] = res_nxt[wide ? 15 : 7];
        // zero when all result bits clear
        calc[cfl_pkg::FLAG_Z] = res_nxt == 16'h0000;
    end

    // ------------------------------------------------------------
    // per-flag update action
    // ------------------------------------------------------------
    // action chosen per flag; don't care keeps the old value
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_flag
        always_comb
        begin
            case (spec_r[gi * cfl_pkg::ACT_W +: cfl_pkg::ACT_W])
                cfl_pkg::ACT_ZERO: flags_nxt[gi] = 1'b0;
                cfl_pkg::ACT_ONE: flags_nxt[gi] = 1'b1;
                cfl_pkg::ACT_COMP: flags_nxt[gi] = calc[gi];
                default: flags_nxt[gi] = flags_r[gi];
            endcase
        end
    end

    // unused flag bits forced to zero
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            flags_r <= cfl_pkg::FLAGS_RST;
            result_r <= cfl_pkg::WORD_RST;
        end
        else if (go_r)
        begin
            flags_r <= flags_nxt & cfl_pkg::FLAG_MASK;
            result_r <= res_nxt;
        end
        else if (wr && paddr == cfl_pkg::ADDR_FLAGS)
            flags_r <= pwdata[7:0] & cfl_pkg::FLAG_MASK;
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign flags_out = flags_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sign_msb: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && !wide && spec_r[21 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[7] == result_r[7])
        else $error("sign flag does not match result msb");
    a_zero_all: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && spec_r[18 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[6] == (result_r == 16'h0000))
        else $error("zero flag does not match result");
    a_parity_even: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_XOR8 && spec_r[6 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[2] == ~^result_r[7:0])
        else $error("parity flag wrong after logic op");
    a_ovf_add: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_ADD8 && spec_r[6 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[2] == ($past(opa_r[7]) == $past(opb_r[7])
                           && result_r[7] != $past(opa_r[7])))
        else $error("overflow flag wrong after add");
    a_half_add: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_ADD8 && spec_r[12 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[4] == ({1'b0, $past(opa_r[3:0])}
                           + {1'b0, $past(opb_r[3:0])} > 5'h0F))
        else $error("half-carry wrong after add");
    a_sub_dir: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && (op_r == cfl_pkg::OP_SUB8 || op_r == cfl_pkg::OP_ADD8)
        && spec_r[3 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[1] == ($past(op_r) == cfl_pkg::OP_SUB8))
        else $error("add/subtract flag wrong");
    a_adj_clean: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_DECADJ && (flags_r & 8'h13) == 8'h00
        && opa_r[3:0] < 4'hA && opa_r[7:4] < 4'hA
        |=> result_r[7:0] == $past(opa_r))
        else $error("adjust changed a valid BCD byte");
    a_carry_add: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_ADD8 && spec_r[0 +: 3] == cfl_pkg::ACT_COMP
        |=> flags_r[0] == ({1'b0, $past(opa_r)} + {1'b0, $past(opb_r)}
                           > 9'h0FF))
        else $error("carry flag wrong after add");
    a_keep_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && spec_r[0 +: 3] == cfl_pkg::ACT_KEEP |=> $stable(flags_r[0]))
        else $error("kept flag changed");
    a_force_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && spec_r[18 +: 3] == cfl_pkg::ACT_ONE |=> flags_r[6])
        else $error("forced flag not set");
    a_word_sum: assert property (@(posedge ref_clk) disable iff (!reset_n)
        go_r && op_r == cfl_pkg::OP_ADD16
        |=> result_r == $past(wacc_r) + $past(wopnd_r) && wacc_r == result_r)
        else $error("word add result wrong");
    a_flag_layout: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ##1 (flags_r & ~cfl_pkg::FLAG_MASK) == 8'h00 && flags_out == flags_r)
        else $error("unused flag bits not zero");
endmodule
`default_nettype wire

// ### hdl/cfl_pkg.sv
`default_nettype none
package cfl_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OPA = 8'h00;
    localparam logic [7:0] ADDR_OPB = 8'h04;
    localparam logic [7:0] ADDR_WACC = 8'h08;
    localparam logic [7:0] ADDR_WOPND = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;

    // ------------------------------------------------------------
    // flag bit positions and command layout
    // ------------------------------------------------------------
    localparam int FLAG_S = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_H = 4;
    localparam int FLAG_PV = 2;
    localparam int FLAG_N = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAG_MASK = 8'hD7;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 5;
    localparam int CMD_SPEC_LSB = 8;
    localparam int ACT_W = 3;
    localparam int SPEC_W = 24;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [23:0] SPEC_RST = 24'h000000;

    typedef enum logic [4:0] {
        OP_ADD8 = 5'h00,
        OP_ADC8 = 5'h01,
        OP_SUB8 = 5'h02,
        OP_SBC8 = 5'h03,
        OP_CMP8 = 5'h04,
        OP_NEG8 = 5'h05,
        OP_INC8 = 5'h06,
        OP_DEC8 = 5'h07,
        OP_AND8 = 5'h08,
        OP_OR8 = 5'h09,
        OP_XOR8 = 5'h0A,
        OP_CPL8 = 5'h0B,
        OP_DECADJ = 5'h0C,
        OP_ADD16 = 5'h10,
        OP_ADC16 = 5'h11,
        OP_SBC16 = 5'h12
    } cfl_op_e;

    typedef enum logic [2:0] {
        ACT_KEEP = 3'h0,
        ACT_ZERO = 3'h1,
        ACT_ONE = 3'h2,
        ACT_COMP = 3'h3,
        ACT_DCARE = 3'h4
    } cfl_act_e;
endpackage
`default_nettype wire

// ### verification/cfl_flag_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module cfl_flag_unit_test;
logic ref_clk;
logic reset_n;
logic psel;
logic penable;
logic pwrite;
logic [7:0] paddr;
logic [31:0] pwdata;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic [7:0] flags_out;
logic [31:0] rd;
logic er;
int n_mismatch;
int tests_run;
logic [23:0] pats [5] = '{24'h000000, 24'h249249, 24'h492492, 24'h6DB6DB,
    24'h924924};

cfl_flag_unit uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flags_out(flags_out));

initial
begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
end

task automatic stop_test;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    tests_run++;
    if (got !== exp)
    begin
        $display("wrong value at %0t: %s got %h expected %h", $time, msg,
            got, exp);
        n_mismatch++;
    end
endtask

// ------------------------------------------------------------
// apb master
// ------------------------------------------------------------
// one idle edge first, so psel is never assigned twice in one step
task automatic apb(input logic wr, input logic [7:0] addr,
    input logic [31:0] wd);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
        @(posedge ref_clk);
        if (pready === 1'b1)
            break;
    end
    if (i == 20)
    begin
        $display("wrong value at %0t: pready never came", $time);
        n_mismatch++;
        stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic rdc(input logic [7:0] addr, input logic [31:0] exp,
    input string msg);
    apb(1'b0, addr, 32'h0);
    chk(rd, exp, msg);
    chk({31'h0, er}, 32'h0, {msg, " error flag"});
endtask

// ------------------------------------------------------------
// expected flags and result
// ------------------------------------------------------------
function automatic logic [23:0] model(input logic [4:0] op,
    input logic [7:0] a, input logic [7:0] b, input logic [15:0] wa,
    input logic [15:0] wb, input logic [7:0] f, input logic [23:0] spec);
    logic [16:0] x, y, r, t;
    logic ci, sub, wd, lg, sx, sy, sr;
    logic [7:0] cf, nf;
    logic [2:0] act;
    x = {9'h0, a};
    y = {9'h0, b};
    r = 17'h0;
    {ci, sub, wd, lg} = 4'h0;
    cf = 8'h0;
    case (op)
        cfl_pkg::OP_ADC8: ci = f[0];
        cfl_pkg::OP_SUB8, cfl_pkg::OP_CMP8: sub = 1'b1;
        cfl_pkg::OP_SBC8: {sub, ci} = {1'b1, f[0]};
        cfl_pkg::OP_NEG8: {x, y, sub} = {17'h0, 9'h0, a, 1'b1};
        cfl_pkg::OP_INC8: y = 17'h1;
        cfl_pkg::OP_DEC8: {y, sub} = {17'h1, 1'b1};
        cfl_pkg::OP_AND8: {r, lg, cf[4]} = {9'h0, a & b, 2'h3};
        cfl_pkg::OP_OR8: {r, lg} = {9'h0, a | b, 1'b1};
        cfl_pkg::OP_XOR8: {r, lg} = {9'h0, a ^ b, 1'b1};
        cfl_pkg::OP_CPL8: {r, lg, cf[4], cf[1]} = {9'h0, ~a, 3'h7};
        cfl_pkg::OP_ADD16: {x, y, wd} = {1'b0, wa, 1'b0, wb, 1'b1};
        cfl_pkg::OP_ADC16: {x, y, wd, ci} = {1'b0, wa, 1'b0, wb, 1'b1, f[0]};
        cfl_pkg::OP_SBC16: {x, y, wd, ci, sub} =
            {1'b0, wa, 1'b0, wb, 1'b1, f[0], 1'b1};
        default: ;
    endcase
    if (lg)
        cf[2] = ~^r[7:0];
    else
    begin
        r = sub ? x - y - {16'h0, ci} : x + y + {16'h0, ci};
        t = x ^ y ^ r;
        cf[4] = wd ? t[12] : t[4];
        cf[0] = wd ? r[16] : r[8];
        cf[1] = sub;
        sx = wd ? x[15] : x[7];
        sy = wd ? y[15] : y[7];
        sr = wd ? r[15] : r[7];
        cf[2] = (sub ? (sx != sy) : (sx == sy)) && (sr != sx);
    end
    cf[7] = wd ? r[15] : r[7];
    cf[6] = wd ? (r[15:0] == 16'h0) : (r[7:0] == 8'h0);
    if (!wd)
        r[16:8] = 9'h0;
    for (int k = 0; k < 8; k++)
    begin
        act = spec[3*k +: 3];
        case (act)
            cfl_pkg::ACT_ZERO: nf[k] = 1'b0;
            cfl_pkg::ACT_ONE: nf[k] = 1'b1;
            cfl_pkg::ACT_COMP: nf[k] = cf[k];
            default: nf[k] = f[k];
        endcase
    end
    return {r[15:0], nf & cfl_pkg::FLAG_MASK};
endfunction

task automatic run_op(input logic [4:0] op, input logic [7:0] a,
    input logic [7:0] b, input logic [15:0] wa, input logic [15:0] wb,
    input logic [7:0] f, input logic [23:0] spec);
    logic [23:0] e;
    logic cmp;
    e = model(op, a, b, wa, wb, f & cfl_pkg::FLAG_MASK, spec);
    cmp = (op == cfl_pkg::OP_CMP8);
    apb(1'b1, cfl_pkg::ADDR_OPA, {24'h0, a});
    apb(1'b1, cfl_pkg::ADDR_OPB, {24'h0, b});
    apb(1'b1, cfl_pkg::ADDR_WACC, {16'h0, wa});
    apb(1'b1, cfl_pkg::ADDR_WOPND, {16'h0, wb});
    apb(1'b1, cfl_pkg::ADDR_FLAGS, {24'h0, f});
    apb(1'b1, cfl_pkg::ADDR_CMD, {spec, 3'h0, op});
    rdc(cfl_pkg::ADDR_FLAGS, {24'h0, e[7:0]}, "flags");
    chk({24'h0, flags_out}, {24'h0, e[7:0]}, "flag port");
    if (!cmp)
        rdc(cfl_pkg::ADDR_RESULT, {16'h0, e[23:8]}, "result");
    rdc(cfl_pkg::ADDR_OPA, {24'h0, (op[4] || cmp) ? a : e[15:8]}, "acc");
    rdc(cfl_pkg::ADDR_WACC, {16'h0, op[4] ? e[23:8] : wa}, "word acc");
endtask

// ------------------------------------------------------------
// main sequence
// ------------------------------------------------------------
initial
begin
    logic [31:0] r1, r2;
    logic [4:0] op;
    logic [23:0] spec;
    int k;
    {reset_n, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    tests_run = 0;
    r1 = $urandom(32'hBD9F61D2);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk({24'h0, flags_out}, 32'h0, "reset flag port");
    for (k = 0; k <= 24; k += 4)
        rdc(8'(k), 32'h0, "reset value");
    $display("test reset values done");
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, er}, 32'h1, "unaligned error");
    chk(rd, 32'h0, "refused read data");
    apb(1'b1, cfl_pkg::ADDR_RESULT, 32'hFFFF);
    rdc(cfl_pkg::ADDR_RESULT, 32'h0, "read-only result");
    apb(1'b1, cfl_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    rdc(cfl_pkg::ADDR_FLAGS, 32'hD7, "flag mask");
    $display("test access kinds done");
    // every action kind over the edges of carry, overflow and zero
    for (k = 0; k < 5; k++)
    begin
        r1 = (k == 0 || k == 4) ? 32'hFF : 32'h0;
        run_op(cfl_pkg::OP_ADD8, 8'h7F, 8'h01, 16'h0, 16'h0, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_SUB8, 8'h80, 8'h01, 16'h0, 16'h0, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_ADD8, 8'hFF, 8'h01, 16'h0, 16'h0, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_SUB8, 8'h00, 8'h01, 16'h0, 16'h0, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_XOR8, 8'hFF, 8'hFF, 16'h0, 16'h0, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_ADD16, 8'h0, 8'h0, 16'hFFFF, 16'h1, r1[7:0], pats[k]);
        run_op(cfl_pkg::OP_SBC16, 8'h0, 8'h0, 16'h8000, 16'h0, 8'h01, pats[k]);
    end
    $display("test corner cases done");
    // addition then subtraction, each followed by a decimal adjust
    run_op(cfl_pkg::OP_ADD8, 8'h15, 8'h27, 16'h0, 16'h0, 8'h00, pats[3]);
    apb(1'b1, cfl_pkg::ADDR_CMD, {pats[3], 3'h0, cfl_pkg::OP_DECADJ});
    rdc(cfl_pkg::ADDR_RESULT, 32'h42, "adjust after add");
    rdc(cfl_pkg::ADDR_FLAGS, 32'h14, "adjust flags add");
    run_op(cfl_pkg::OP_SUB8, 8'h42, 8'h15, 16'h0, 16'h0, 8'h00, pats[3]);
    apb(1'b1, cfl_pkg::ADDR_CMD, {pats[3], 3'h0, cfl_pkg::OP_DECADJ});
    rdc(cfl_pkg::ADDR_RESULT, 32'h27, "adjust after sub");
    rdc(cfl_pkg::ADDR_FLAGS, 32'h06, "adjust flags sub");
    // a valid BCD byte with clean flags must pass through unchanged
    run_op(cfl_pkg::OP_ADD8, 8'h12, 8'h34, 16'h0, 16'h0, 8'h00, pats[3]);
    apb(1'b1, cfl_pkg::ADDR_CMD, {pats[3], 3'h0, cfl_pkg::OP_DECADJ});
    rdc(cfl_pkg::ADDR_RESULT, 32'h46, "adjust keeps bcd");
    rdc(cfl_pkg::ADDR_FLAGS, 32'h00, "adjust flags bcd");
    $display("test decimal adjust done");
    for (int i = 0; i < 250; i++)
    begin
        k = $urandom_range(0, 14);
        op = 5'(k < 12 ? k : k + 4);
        r1 = $urandom;
        r2 = $urandom;
        spec = 24'($urandom);
        run_op(op, r1[7:0], r1[15:8], r1[31:16], r2[15:0], r2[23:16], spec);
    end
    $display("test random operations done");
    stop_test();
end
endmodule
`default_nettype wire
